/* File: core/bam_pkg.sv */
// Package: register map, field positions and states of the breakpoint unit.
// Assumes classic Wishbone with 8-bit data on a 4-bit byte address map.
package bam_pkg;
  localparam int BAM_AW = 4;
  localparam logic [BAM_AW-1:0] BAM_OFS_CTRL = 4'h0;
  localparam logic [BAM_AW-1:0] BAM_OFS_ADDR_HI = 4'h4;
  localparam logic [BAM_AW-1:0] BAM_OFS_ADDR_LO = 4'h8;
  localparam logic [BAM_AW-1:0] BAM_OFS_LP_STAT = 4'hC;
  localparam logic [BAM_AW-1:0] BAM_OFS_FLAG_CTL = 4'h1;
  localparam logic [BAM_AW-1:0] BAM_OFS_IRQ_STAT = 4'h2;
  localparam logic [BAM_AW-1:0] BAM_OFS_IRQ_MASK = 4'h3;
  localparam int BAM_BIT_MATCH_EN = 7;
  localparam int BAM_BIT_ACTIVE = 6;
  localparam int BAM_BIT_LP_EXIT = 1;
  localparam int BAM_BIT_CLR_EN = 7;
  localparam int BAM_IRQ_ENTRY = 0;
  localparam int BAM_IRQ_LP_EXIT = 1;
  localparam logic [7:0] BAM_RST_BYTE = 8'h00;
  localparam logic [15:0] BAM_VEC_NORMAL = 16'hFFFC;
  localparam logic [15:0] BAM_VEC_MONITOR = 16'hFEFC;
  localparam logic [7:0] BAM_OP_SOFT_INT = 8'h83;
  typedef enum logic [1:0] {BAM_IDLE, BAM_PEND, BAM_BREAK} bam_state_e;
endpackage : bam_pkg

/* File: core/bam_cpu_if.sv */
// Interface: CPU core side signals between the unit and its front end.
// Assumes one clock domain shared with the core.
`timescale 1ns/1ps
interface bam_cpu_if;
  logic [15:0] addr;
  logic cpu_owns_bus;
  logic fetch_valid;
  logic hit;
  modport unit (input addr, cpu_owns_bus, fetch_valid, output hit);
  modport cmp (output addr, cpu_owns_bus, fetch_valid, input hit);
endinterface : bam_cpu_if

/* File: core/bam_addr_cmp.sv */
// Address comparator: raises hit when a CPU-owned address equals the
// breakpoint. Assumes addresses are valid while fetch_valid is high.
`timescale 1ns/1ps
module bam_addr_cmp (
  bam_cpu_if.unit cpu,
  input wire logic enable_i,
  input wire logic [15:0] bp_addr_i
);
  import bam_pkg::*;
  // Other masters never qualify
  assign cpu.hit = enable_i & cpu.cpu_owns_bus & cpu.fetch_valid &
                   (cpu.addr == bp_addr_i); // [RL1] [RL2]
endmodule : bam_addr_cmp

/* File: core/bam_top.sv */
// Breakpoint unit: address match, forced break, break state, wake flag.
// Assumes CPU core obeys brk_req_o at instruction boundaries.
// Function
// [RL1] While match enable set, request a break when address equals breakpoint.
// [RL2] Only program counter addresses from the CPU may match.
// [RL3] CPU finishes current instruction then loads soft interrupt opcode.
// [RL4] Match on last instruction cycle starts the break at once.
// [RL5] Vector FFFC/FFFD normally, FEFC/FEFD in monitor mode.
// [RL6] Break state lasts until interrupt return completes.
// [RL7] Match enable is bit 7, read/write, reset zero.
// [RL8] Active flag set on match by hardware, reset zero.
// [RL9] Writing one to active flag forces break; software clears it.
// [RL10] Breakpoint held in high and low byte registers, reset zero.
// [RL11] Timers halt while break state is active.
// [RL12] Watchdog held off in break when test high voltage present.
// [RL13] Break wakes from stop and sets low-power exit flag.
// [RL14] Exit flag also set leaving wait; write zero clears; readable.
// [RL15] Routine may decrement stacked return address when flag set.
// [RL16] Clear enable decides if status flags clear during break.
// [RL17] With clear enable zero, flag clear writes during break ignored; the unit still takes clears of its own lp_exit and irq_stat.
// [RL18] Flags cleared during enabled break stay cleared afterwards.
// [RL19] One break-state signal drives freeze, watchdog and protection.
`timescale 1ns/1ps
module bam_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [bam_pkg::BAM_AW-1:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  output logic [7:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic [15:0] cpu_addr_i,
  input wire logic cpu_owns_bus_i,
  input wire logic cpu_fetch_i,
  input wire logic cpu_last_cycle_i,
  input wire logic cpu_swi_taken_i,
  input wire logic cpu_rti_done_i,
  input wire logic monitor_mode_i,
  input wire logic wait_mode_i,
  input wire logic stop_mode_i,
  input wire logic test_high_voltage_i,
  output logic brk_req_o,
  output logic [7:0] brk_opcode_o,
  output logic [15:0] brk_vector_o,
  output logic break_state_o,
  output logic timer_halt_o,
  output logic watchdog_off_o,
  output logic flag_clear_allow_o,
  output logic wake_o,
  output logic irq_o
);
  import bam_pkg::*;

  typedef struct packed {
    bam_state_e st;
    logic [7:0] ctrl;
    logic [7:0] hi;
    logic [7:0] lo;
    logic lp_exit;
    logic clr_en;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic ack;
    logic [7:0] rdata;
  } bam_state_s;

  bam_state_s state_reg;
  bam_state_s state_next;
  logic hit;
  logic acc;
  logic wr;
  logic force_brk;

  function automatic logic [7:0] bam_read(input bam_state_s s,
                                           input logic [BAM_AW-1:0] a);
    bam_read = BAM_RST_BYTE;
    case (a)
      BAM_OFS_CTRL: bam_read = s.ctrl;
      BAM_OFS_ADDR_HI: bam_read = s.hi;
      BAM_OFS_ADDR_LO: bam_read = s.lo;
      BAM_OFS_LP_STAT: bam_read = {6'h00, s.lp_exit, 1'b0};
      BAM_OFS_FLAG_CTL: bam_read = {s.clr_en, 7'h00};
      BAM_OFS_IRQ_STAT: bam_read = {6'h00, s.irq_stat};
      BAM_OFS_IRQ_MASK: bam_read = {6'h00, s.irq_mask};
      default: bam_read = BAM_RST_BYTE;
    endcase
  endfunction : bam_read

  bam_cpu_if cpu_bus ();
  assign cpu_bus.addr = cpu_addr_i;
  assign cpu_bus.cpu_owns_bus = cpu_owns_bus_i;
  assign cpu_bus.fetch_valid = cpu_fetch_i;

  bam_addr_cmp u_cmp (
    .cpu(cpu_bus.unit),
    .enable_i(state_reg.ctrl[BAM_BIT_MATCH_EN]),
    .bp_addr_i({state_reg.hi, state_reg.lo})
  );
  assign hit = cpu_bus.hit;

  // Ack one cycle after strobe; dropped the cycle after it was given
  assign acc = wb_cyc_i & wb_stb_i & ~state_reg.ack;
  assign wr = acc & wb_we_i & wb_sel_i;
  assign force_brk = wr && wb_adr_i == BAM_OFS_CTRL &&
                     wb_dat_i[BAM_BIT_ACTIVE]; // [RL9]

  always_comb begin
    state_next = state_reg;
    state_next.ack = acc;
    state_next.rdata = acc ? bam_read(state_reg, wb_adr_i) : BAM_RST_BYTE;
    if (wr) begin
      case (wb_adr_i)
        BAM_OFS_CTRL: begin
          state_next.ctrl[BAM_BIT_MATCH_EN] = wb_dat_i[BAM_BIT_MATCH_EN]; // [RL7]
          state_next.ctrl[BAM_BIT_ACTIVE] = wb_dat_i[BAM_BIT_ACTIVE]; // [RL9]
        end
        BAM_OFS_ADDR_HI: state_next.hi = wb_dat_i; // [RL10]
        BAM_OFS_ADDR_LO: state_next.lo = wb_dat_i; // [RL10]
        BAM_OFS_LP_STAT: begin
          // Only a zero clears; ones are ignored
          if (!wb_dat_i[BAM_BIT_LP_EXIT]) begin
            state_next.lp_exit = 1'b0; // [RL14]
          end
        end
        BAM_OFS_FLAG_CTL: state_next.clr_en = wb_dat_i[BAM_BIT_CLR_EN]; // [RL16]
        BAM_OFS_IRQ_STAT: state_next.irq_stat = state_reg.irq_stat &
                                                ~wb_dat_i[1:0];
        BAM_OFS_IRQ_MASK: state_next.irq_mask = wb_dat_i[1:0];
        default: state_next.ctrl = state_next.ctrl;
      endcase
    end
    // Hardware set wins over a same-cycle clear
    if (hit) begin
      state_next.ctrl[BAM_BIT_ACTIVE] = 1'b1; // [RL8]
    end
    case (state_reg.st)
      BAM_IDLE: begin
        if (hit || force_brk) begin
          state_next.st = BAM_PEND; // [RL1] [RL9]
          if (wait_mode_i || stop_mode_i) begin
            state_next.lp_exit = 1'b1; // [RL13] [RL14]
            state_next.irq_stat[BAM_IRQ_LP_EXIT] = 1'b1;
          end
        end
      end
      BAM_PEND: begin
        if (cpu_swi_taken_i) begin
          state_next.st = BAM_BREAK; // [RL3]
          state_next.irq_stat[BAM_IRQ_ENTRY] = 1'b1;
        end
      end
      BAM_BREAK: begin
        if (cpu_rti_done_i) begin
          state_next.st = BAM_IDLE; // [RL6]
        end
      end
      default: state_next.st = BAM_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0; // [RL7] [RL8] [RL10] [RL14] [RL17]
      state_reg.st <= BAM_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Request is live in the hit cycle so a last-cycle match breaks at once
  assign brk_req_o = (state_reg.st == BAM_PEND) ||
                     (state_reg.st == BAM_IDLE &&
                      (hit || force_brk)); // [RL4] [RL3]
  assign brk_opcode_o = BAM_OP_SOFT_INT; // [RL3]
  assign brk_vector_o = monitor_mode_i ? BAM_VEC_MONITOR
                                       : BAM_VEC_NORMAL; // [RL5]
  assign break_state_o = state_reg.st == BAM_BREAK; // [RL19]
  assign timer_halt_o = break_state_o; // [RL11]
  assign watchdog_off_o = break_state_o & test_high_voltage_i; // [RL12]
  // Peripherals gate their flag clears with this; a clear taken is final
  assign flag_clear_allow_o = ~break_state_o | state_reg.clr_en; // [RL17] [RL18]
  assign wake_o = brk_req_o & stop_mode_i; // [RL13]
  assign irq_o = |(state_reg.irq_stat & state_reg.irq_mask);
  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.rdata;
endmodule : bam_top

/* File: sim/bam_cpu_model.sv */
// CPU core model: takes a break on the LAT+1th cycle of brk_req_i, returns on ret_i.
// Assumes one clock shared with the unit.
`timescale 1ns/1ps
module bam_cpu_model #(
  parameter int LAT = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic brk_req_i,
  input wire logic ret_i,
  output logic swi_o,
  output logic rti_o
);
  int cnt;
  logic in_brk;
  always @(posedge clk_i) begin
    swi_o <= 1'b0;
    rti_o <= 1'b0;
    if (rst_i) begin
      cnt <= 0;
      in_brk <= 1'b0;
    end else if (!in_brk && brk_req_i) begin
      // Slow instruction must finish first
      cnt <= (cnt == LAT) ? 0 : cnt + 1;
      swi_o <= (cnt == LAT);
      in_brk <= (cnt == LAT);
    end else if (in_brk && ret_i) begin
      rti_o <= 1'b1;
      in_brk <= 1'b0;
    end
  end
endmodule : bam_cpu_model

/* File: sim/bam_top_asserts.sv */
// Checker: break entry, exit and derived outputs.
// Assumes it is bound to bam_top and sees only its ports.
`timescale 1ns/1ps
module bam_top_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cpu_swi_taken_i,
  input wire logic cpu_rti_done_i,
  input wire logic monitor_mode_i,
  input wire logic stop_mode_i,
  input wire logic test_high_voltage_i,
  input wire logic brk_req_o,
  input wire logic [15:0] brk_vector_o,
  input wire logic break_state_o,
  input wire logic timer_halt_o,
  input wire logic watchdog_off_o,
  input wire logic wake_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_halt; timer_halt_o == break_state_o; endproperty
  a_halt: assert property (p_halt) else $error("timer halt wrong");
  property p_wdog;
    watchdog_off_o == (break_state_o && test_high_voltage_i);
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog wrong");
  property p_vec;
    brk_vector_o == (monitor_mode_i ? 16'hFEFC : 16'hFFFC);
  endproperty
  a_vec: assert property (p_vec) else $error("vector wrong");
  property p_wake; wake_o == (brk_req_o && stop_mode_i); endproperty
  a_wake: assert property (p_wake) else $error("wake wrong");
  property p_enter; $rose(break_state_o) |-> $past(cpu_swi_taken_i); endproperty
  a_enter: assert property (p_enter) else $error("early break");
  property p_exit; break_state_o && cpu_rti_done_i |=> !break_state_o; endproperty
  a_exit: assert property (p_exit) else $error("break stuck");
  property p_hold; break_state_o && !cpu_rti_done_i |=> break_state_o; endproperty
  a_hold: assert property (p_hold) else $error("break lost");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
endmodule : bam_top_asserts

/* File: sim/bam_top_tb.sv */
// Bench: register table, address match, forced break, wake flag.
// Assumes bam_top, the CPU model and the checker.
`timescale 1ns/1ps
module bam_top_tb;
  import bam_pkg::*;
  logic clk_i, rst_i, wb_we_i, wb_sel_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [BAM_AW-1:0] wb_adr_i;
  logic [7:0] wb_dat_i, wb_dat_o, brk_opcode_o, rd;
  logic [15:0] cpu_addr_i, brk_vector_o;
  logic cpu_owns_bus_i, cpu_fetch_i, cpu_last_cycle_i, cpu_swi_taken_i;
  logic cpu_rti_done_i, monitor_mode_i, wait_mode_i, stop_mode_i, ret;
  logic test_high_voltage_i, brk_req_o, break_state_o, timer_halt_o;
  logic watchdog_off_o, flag_clear_allow_o, wake_o, irq_o;
  int error_cnt = 0;
  int checks = 0;
  typedef struct {logic [3:0] a; logic [7:0] w, e;} bam_row_s;
  bam_row_s rows[7] = '{'{BAM_OFS_CTRL, 8'h80, 8'h80},
    '{BAM_OFS_ADDR_HI, 8'h12, 8'h12}, '{BAM_OFS_ADDR_LO, 8'h34, 8'h34},
    '{4'h5, 8'hFF, 8'h00}, '{BAM_OFS_FLAG_CTL, 8'h80, 8'h80},
    '{BAM_OFS_FLAG_CTL, 8'h00, 8'h00}, '{BAM_OFS_IRQ_MASK, 8'h03, 8'h03}};
  bam_top u_bam_top (.*);
  bam_cpu_model u_bam_cpu_model (.clk_i, .rst_i, .brk_req_i(brk_req_o),
    .ret_i(ret), .swi_o(cpu_swi_taken_i), .rti_o(cpu_rti_done_i));
  task automatic chk(input string n, input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task final_report;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // Held until ack is sampled; read data taken at that edge only
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_sel_i, wb_we_i, wb_adr_i, wb_dat_i} <=
      {3'b111, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
      if (n > 20) begin
        chk("ack", 0, 1);
        final_report();
      end
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_sel_i} <= 3'b000;
  endtask : wb
  task automatic wt(input logic v);
    for (int i = 0; i < 40 && break_state_o !== v; i++) @(negedge clk_i);
    chk("state", break_state_o, v);
    if (break_state_o !== v) final_report();
  endtask : wt
  task automatic interrupt_return_opcode;
    @(posedge clk_i) ret <= 1'b1;
    @(posedge clk_i) ret <= 1'b0;
    wt(0);
  endtask : interrupt_return_opcode
  initial begin
    clk_i = 0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    {wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i, cpu_addr_i} = '0;
    {cpu_owns_bus_i, cpu_fetch_i, cpu_last_cycle_i, monitor_mode_i} = '0;
    {wait_mode_i, stop_mode_i, test_high_voltage_i, ret, wb_sel_i} = '0;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      wb(0, rows[i].a, 0);
      chk("reset", rd, 0);
    end
    foreach (rows[i]) begin
      wb(1, rows[i].a, rows[i].w);
      wb(0, rows[i].a, 0);
      chk("reg", rd, rows[i].e);
    end
    @(posedge clk_i) {cpu_addr_i, cpu_fetch_i, stop_mode_i} <= {16'h1234, 2'b11};
    @(negedge clk_i) chk("foreign", brk_req_o, 0);
    @(posedge clk_i) cpu_owns_bus_i <= 1'b1;
    @(negedge clk_i) chk("req", brk_req_o, 1);
    chk("wake", wake_o, 1);
    wt(1);
    chk("halt", timer_halt_o, 1);
    chk("wdog off", watchdog_off_o, 0);
    chk("vec", brk_vector_o, BAM_VEC_NORMAL);
    chk("opcode", brk_opcode_o, BAM_OP_SOFT_INT);
    @(posedge clk_i) {cpu_fetch_i, stop_mode_i} <= 2'b00;
    wb(0, BAM_OFS_CTRL, 0);
    chk("active", rd, 8'hC0);
    wb(0, BAM_OFS_LP_STAT, 0);
    chk("lp", rd, 8'h02);
    chk("protect", flag_clear_allow_o, 0);
    wb(0, BAM_OFS_IRQ_STAT, 0);
    chk("irq stat", rd, 8'h03);
    chk("irq on", irq_o, 1);
    wb(1, BAM_OFS_IRQ_STAT, 8'h03);
    @(negedge clk_i) chk("irq", irq_o, 0);
    wb(1, BAM_OFS_LP_STAT, 0);
    wb(0, BAM_OFS_LP_STAT, 0);
    chk("lp clr", rd, 0);
    wb(1, BAM_OFS_FLAG_CTL, 8'h80);
    @(negedge clk_i) chk("allow", flag_clear_allow_o, 1);
    wb(1, BAM_OFS_CTRL, 8'h80);
    wb(0, BAM_OFS_CTRL, 0);
    chk("active clr", rd, 8'h80);
    interrupt_return_opcode();
    @(posedge clk_i) {monitor_mode_i, wait_mode_i, test_high_voltage_i} <= 3'b111;
    wb(1, BAM_OFS_CTRL, 8'h40);
    wt(1);
    chk("wdog", watchdog_off_o, 1);
    chk("vec mon", brk_vector_o, BAM_VEC_MONITOR);
    wb(0, BAM_OFS_LP_STAT, 0);
    chk("lp wait", rd, 8'h02);
    wb(1, BAM_OFS_CTRL, 0);
    interrupt_return_opcode();
    chk("idle", brk_req_o, 0);
    wb(1, BAM_OFS_CTRL, 8'h40);
    wt(1);
    // Reset mid-break must drop the break, the control byte and the low-power exit flag
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i) chk("rst brk", break_state_o, 0);
    wb(0, BAM_OFS_CTRL, 0);
    chk("rst ctrl", rd, 0);
    wb(0, BAM_OFS_LP_STAT, 0);
    chk("rst lp", rd, 0);
    final_report();
  end
endmodule : bam_top_tb
bind bam_top bam_top_asserts u_bam_top_asserts (.*);
